// ==== design/ecf_pkg.sv ====
// Shared constants and types for the enhanced core feature block
package ecf_pkg;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam int ECF_AW = 8;
   localparam logic [7:0] ECF_A_INSCTL = 8'h00;
   localparam logic [7:0] ECF_A_AUX = 8'h04;
   localparam logic [7:0] ECF_A_DPTR0 = 8'h08;
   localparam logic [7:0] ECF_A_SECOND_DATA_POINTER = 8'h0C;
   localparam logic [7:0] ECF_A_DPTRACT = 8'h10;
   localparam logic [7:0] ECF_A_EXT_RAM_PAGE = 8'h14;
   localparam logic [7:0] ECF_A_FLASH = 8'h18;
   localparam logic [7:0] ECF_A_SFRPG = 8'h1C;
   localparam logic [7:0] ECF_A_ACC = 8'h20;
   localparam logic [7:0] ECF_A_BREG = 8'h24;
   localparam logic [7:0] ECF_A_ARITH = 8'h28;
   localparam logic [7:0] ECF_A_DBGCTL = 8'h2C;
   localparam logic [7:0] ECF_A_BPADDR = 8'h30;
   localparam logic [7:0] ECF_A_DBGSTAT = 8'h34;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int ECF_INS_DPS_BIT = 0;
   localparam int ECF_INS_DIV_BIT = 2;
   localparam int ECF_INS_MUL_BIT = 3;
   localparam int ECF_FLASH_FAC_BIT = 0;
   localparam int ECF_ARITH_MUL_BIT = 0;
   localparam int ECF_ARITH_DIV_BIT = 1;
   localparam int ECF_DBG_ENTER_BIT = 0;
   localparam int ECF_DBG_RESUME_BIT = 1;
   localparam int ECF_DBG_STEP_BIT = 2;
   localparam int ECF_DBG_SOVER_BIT = 3;
   localparam int ECF_DBG_BPCLR_BIT = 4;
   localparam int ECF_DBG_EXIT_BIT = 5;
   localparam int ECF_STAT_HALT_BIT = 0;
   localparam int ECF_STAT_DBG_BIT = 1;
   localparam int ECF_STAT_DIVZ_BIT = 2;
   localparam int ECF_STAT_BPCNT_LSB = 4;

   // ----------------------------------------------------------------
   // Reset and debug values
   // ----------------------------------------------------------------
   localparam logic [7:0] ECF_BYTE_RST = 8'h00;
   localparam logic [3:0] ECF_PIN_OE_N_RST = 4'hF;
   localparam logic [15:0] ECF_DBG_PC_ENTRY = 16'h0000;
   localparam logic [7:0] ECF_DBG_SP_ENTRY = 8'h07;
   localparam int ECF_BP_MAX = 7;
   localparam logic [2:0] ECF_BP_PTR_LAST = 3'h6;
   localparam logic [2:0] ECF_BP_CNT_FULL = 3'h7;

   // Debug run state, one-hot
   typedef enum logic [3:0] {
      ECF_DS_RUN = 4'h1,
      ECF_DS_HALT = 4'h2,
      ECF_DS_STEP = 4'h4,
      ECF_DS_SOVER = 4'h8
   } ecf_dstate_t;

endpackage

// ==== design/ecf_bp_table.sv ====
// Hardware breakpoint table keeping the most recently set addresses
module ecf_bp_table (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic set_valid,
   input wire logic [15:0] set_addr,
   input wire logic clear_all,
   input wire logic [15:0] match_pc,
   output logic match,
   output logic [2:0] count
);

   typedef struct packed {
      logic [ecf_pkg::ECF_BP_MAX-1:0][15:0] addr;
      logic [ecf_pkg::ECF_BP_MAX-1:0] valid;
      logic [2:0] wr_ptr;
      logic [2:0] count;
   } ecf_bp_st_t;

   ecf_bp_st_t st;
   ecf_bp_st_t next_st;

   // Compare a pc against every live entry
   function automatic logic ecf_bp_hit(input ecf_bp_st_t s, input logic [15:0] pc);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < ecf_pkg::ECF_BP_MAX; i++) begin
         if (s.valid[i] && s.addr[i] == pc) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   // Ring write: a new entry overwrites the oldest once full
   always_comb begin
      next_st = st;
      if (clear_all) begin
         next_st.valid = '0;
         next_st.wr_ptr = 3'h0;
         next_st.count = 3'h0;
      end else if (set_valid) begin
         next_st.addr[st.wr_ptr] = set_addr;
         next_st.valid[st.wr_ptr] = 1'b1;
         next_st.wr_ptr = (st.wr_ptr == ecf_pkg::ECF_BP_PTR_LAST) ? 3'h0 : st.wr_ptr + 3'h1;
         if (st.count != ecf_pkg::ECF_BP_CNT_FULL) begin
            next_st.count = st.count + 3'h1;
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign match = ecf_bp_hit(st, match_pc);
   assign count = st.count;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_BP_COUNT_MAX: assert property (count <= ecf_pkg::ECF_BP_CNT_FULL && $countones(st.valid) == count)
      else $error("breakpoint count disagrees with live entries");
   AST_BP_SET_MATCH: assert property ((set_valid && !clear_all) |=> ecf_bp_hit(st, $past(set_addr)))
      else $error("newest breakpoint not active");

endmodule // ecf_bp_table

// ==== design/ecf_core_ext.sv ====
// Enhanced core features: wide arithmetic, dual pointers, paging, debug control
//
// What this block does
// - The core advances one machine cycle on every clock, with no divide by 12.
// - With the wide select bits set, multiply and divide work on 16 by 8 bits using aux_operand_reg.
// - Two data pointers exist and pointer_select in instruction_ctrl_reg picks the one used.
// - Indirect external RAM moves take the high address byte from ext_ram_page.
// - The device resets on a low level of the reset pin.
// - flash_area_sel steers flash access to the main or the information block.
// - The special register space is banked by two page bits.
// - On debug entry the pc is held at 0000H and the stack pointer reads 07H.
// - A breakpoint halts the core after the instruction at its address completes.
// - Step-over at a call runs the routine and halts at the instruction after the call.
// - At most seven breakpoints work, the seven most recently set.
// - While debugging or downloading the shared pins serve only the debug port.
// - flash_area_sel low selects the main block, high the information block.
module ecf_core_ext (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic retire_valid,
   input wire logic [15:0] retire_pc,
   input wire logic [15:0] retire_next_pc,
   input wire logic retire_is_call,
   input wire logic [15:0] retire_ret_pc,
   input wire logic dptr_inc,
   input wire logic ri_valid,
   input wire logic [7:0] ri_value,
   output logic core_run,
   output logic core_halt,
   output logic pc_load,
   output logic [15:0] pc_load_value,
   output logic [7:0] sp_load_value,
   output logic [15:0] dptr_addr,
   output logic [15:0] xram_addr,
   output logic flash_area_sel,
   output logic [1:0] sfr_page,
   input wire logic jtag_sel,
   input wire logic jtag_tdo,
   input wire logic jtag_tdo_en,
   output logic [3:0] jtag_di,
   input wire logic [3:0] gp_do,
   input wire logic [3:0] gp_oe_n,
   output logic [3:0] gp_di,
   input wire logic [3:0] pin_di,
   output logic [3:0] pin_do,
   output logic [3:0] pin_oe_n
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic pointer_select;
      logic wide_div_sel;
      logic wide_mul_sel;
      logic [7:0] aux_operand_reg;
      logic [15:0] dptr0;
      logic [15:0] second_data_pointer;
      logic [7:0] ext_ram_page;
      logic flash_area_sel;
      logic sfr_page_sel_hi;
      logic sfr_page_sel_lo;
      logic [7:0] acc;
      logic [7:0] breg;
      logic divz;
      logic [31:0] prdata;
      logic dbg_mode;
      ecf_pkg::ecf_dstate_t dstate;
      logic so_armed;
      logic [15:0] so_target;
      logic pc_load;
      logic jtag_s1;
      logic jtag_s2;
      logic [3:0] pin_s1;
      logic [3:0] pin_s2;
      logic [3:0] pin_do;
      logic [3:0] pin_oe_n;
      logic [3:0] gp_di;
      logic [3:0] jtag_di;
      logic [15:0] xram_addr;
   } ecf_core_st_t;

   ecf_core_st_t st;
   ecf_core_st_t next_st;
   logic rst_s1;
   logic rst_n;
   logic wr_en;
   logic dbg_wr;
   logic bp_set;
   logic bp_clr;
   logic bp_hit;
   logic [2:0] bp_count;
   logic owns_pins;
   logic [23:0] prod16;
   logic [15:0] quot16;
   logic [7:0] rem16;

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   // low level resets
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // ----------------------------------------------------------------
   // Bus decode and helpers
   // ----------------------------------------------------------------
   // Address map check used by the error answer
   function automatic logic ecf_mapped(input logic [7:0] a);
      return a[1:0] == 2'h0 && a <= ecf_pkg::ECF_A_DBGSTAT;
   endfunction

   assign wr_en = psel && penable && pwrite && ecf_mapped(paddr);
   assign dbg_wr = wr_en && paddr == ecf_pkg::ECF_A_DBGCTL;
   assign bp_set = wr_en && paddr == ecf_pkg::ECF_A_BPADDR;
   assign bp_clr = dbg_wr && pwdata[ecf_pkg::ECF_DBG_BPCLR_BIT];
   assign pready = 1'b1;
   assign pslverr = psel && penable && !ecf_mapped(paddr);
   assign owns_pins = st.jtag_s2 || st.dbg_mode;
   assign prod16 = {st.aux_operand_reg, st.acc} * st.breg;
   assign quot16 = {st.aux_operand_reg, st.acc} / {8'h00, st.breg};
   assign rem16 = 8'({st.aux_operand_reg, st.acc} % {8'h00, st.breg});

   ecf_bp_table u_bp (
      .clk(clk),
      .rst_n(rst_n),
      .set_valid(bp_set),
      .set_addr(pwdata[15:0]),
      .clear_all(bp_clr),
      .match_pc(retire_pc),
      .match(bp_hit),
      .count(bp_count)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.pc_load = 1'b0;
      next_st.jtag_s1 = jtag_sel;
      next_st.jtag_s2 = st.jtag_s1;
      next_st.pin_s1 = pin_di;
      next_st.pin_s2 = st.pin_s1;

      // Read data captured in the setup phase
      if (psel && !penable) begin
         next_st.prdata = 32'h0;
         case (paddr)
            ecf_pkg::ECF_A_INSCTL: begin
               next_st.prdata[ecf_pkg::ECF_INS_DPS_BIT] = st.pointer_select;
               next_st.prdata[ecf_pkg::ECF_INS_DIV_BIT] = st.wide_div_sel;
               next_st.prdata[ecf_pkg::ECF_INS_MUL_BIT] = st.wide_mul_sel;
            end
            ecf_pkg::ECF_A_AUX: next_st.prdata[7:0] = st.aux_operand_reg;
            ecf_pkg::ECF_A_DPTR0: next_st.prdata[15:0] = st.dptr0;
            ecf_pkg::ECF_A_SECOND_DATA_POINTER: next_st.prdata[15:0] = st.second_data_pointer;
            ecf_pkg::ECF_A_DPTRACT: next_st.prdata[15:0] = dptr_addr;
            ecf_pkg::ECF_A_EXT_RAM_PAGE: next_st.prdata[7:0] = st.ext_ram_page;
            ecf_pkg::ECF_A_FLASH: next_st.prdata[ecf_pkg::ECF_FLASH_FAC_BIT] = st.flash_area_sel;
            ecf_pkg::ECF_A_SFRPG: next_st.prdata[1:0] = sfr_page;
            ecf_pkg::ECF_A_ACC: next_st.prdata[7:0] = st.acc;
            ecf_pkg::ECF_A_BREG: next_st.prdata[7:0] = st.breg;
            ecf_pkg::ECF_A_DBGSTAT: begin
               next_st.prdata[ecf_pkg::ECF_STAT_HALT_BIT] = core_halt;
               next_st.prdata[ecf_pkg::ECF_STAT_DBG_BIT] = st.dbg_mode;
               next_st.prdata[ecf_pkg::ECF_STAT_DIVZ_BIT] = st.divz;
               next_st.prdata[ecf_pkg::ECF_STAT_BPCNT_LSB +: 3] = bp_count;
            end
            default: next_st.prdata = 32'h0;
         endcase
      end

      if (dptr_inc) begin
         if (st.pointer_select) begin
            next_st.second_data_pointer = st.second_data_pointer + 16'h0001;
         end else begin
            next_st.dptr0 = st.dptr0 + 16'h0001;
         end
      end

      if (ri_valid) begin
         next_st.xram_addr = {st.ext_ram_page, ri_value};
      end

      // Register writes
      if (wr_en) begin
         case (paddr)
            ecf_pkg::ECF_A_INSCTL: begin
               next_st.pointer_select = pwdata[ecf_pkg::ECF_INS_DPS_BIT];
               next_st.wide_div_sel = pwdata[ecf_pkg::ECF_INS_DIV_BIT];
               next_st.wide_mul_sel = pwdata[ecf_pkg::ECF_INS_MUL_BIT];
            end
            ecf_pkg::ECF_A_AUX: next_st.aux_operand_reg = pwdata[7:0];
            ecf_pkg::ECF_A_DPTR0: next_st.dptr0 = pwdata[15:0];
            ecf_pkg::ECF_A_SECOND_DATA_POINTER: next_st.second_data_pointer = pwdata[15:0];
            ecf_pkg::ECF_A_DPTRACT: begin
               if (st.pointer_select) begin
                  next_st.second_data_pointer = pwdata[15:0];
               end else begin
                  next_st.dptr0 = pwdata[15:0];
               end
            end
            ecf_pkg::ECF_A_EXT_RAM_PAGE: next_st.ext_ram_page = pwdata[7:0];
            ecf_pkg::ECF_A_FLASH: next_st.flash_area_sel = pwdata[ecf_pkg::ECF_FLASH_FAC_BIT];
            ecf_pkg::ECF_A_SFRPG: begin
               next_st.sfr_page_sel_hi = pwdata[1];
               next_st.sfr_page_sel_lo = pwdata[0];
            end
            ecf_pkg::ECF_A_ACC: next_st.acc = pwdata[7:0];
            ecf_pkg::ECF_A_BREG: next_st.breg = pwdata[7:0];
            ecf_pkg::ECF_A_ARITH: begin
               if (pwdata[ecf_pkg::ECF_ARITH_MUL_BIT]) begin
                  if (st.wide_mul_sel) begin
                     {next_st.breg, next_st.aux_operand_reg, next_st.acc} = prod16;
                  end else begin
                     {next_st.breg, next_st.acc} = st.acc * st.breg;
                  end
               end else if (pwdata[ecf_pkg::ECF_ARITH_DIV_BIT]) begin
                  next_st.divz = st.breg == 8'h00;
                  if (st.breg != 8'h00) begin
                     if (st.wide_div_sel) begin
                        {next_st.aux_operand_reg, next_st.acc} = quot16;
                        next_st.breg = rem16;
                     end else begin
                        next_st.acc = st.acc / st.breg;
                        next_st.breg = st.acc % st.breg;
                     end
                  end
               end
            end
            default: next_st.divz = st.divz;
         endcase
      end

      // Debug run control
      case (st.dstate)
         ecf_pkg::ECF_DS_RUN: begin
            if (retire_valid && bp_hit) begin
               next_st.dstate = ecf_pkg::ECF_DS_HALT;
            end
         end
         ecf_pkg::ECF_DS_HALT: begin
            if (dbg_wr && pwdata[ecf_pkg::ECF_DBG_RESUME_BIT]) begin
               next_st.dstate = ecf_pkg::ECF_DS_RUN;
            end else if (dbg_wr && pwdata[ecf_pkg::ECF_DBG_STEP_BIT]) begin
               next_st.dstate = ecf_pkg::ECF_DS_STEP;
            end else if (dbg_wr && pwdata[ecf_pkg::ECF_DBG_SOVER_BIT]) begin
               next_st.dstate = ecf_pkg::ECF_DS_SOVER;
               next_st.so_armed = 1'b0;
            end else if (dbg_wr && pwdata[ecf_pkg::ECF_DBG_EXIT_BIT]) begin
               next_st.dstate = ecf_pkg::ECF_DS_RUN;
               next_st.dbg_mode = 1'b0;
            end
         end
         ecf_pkg::ECF_DS_STEP: begin
            if (retire_valid) begin
               next_st.dstate = ecf_pkg::ECF_DS_HALT;
            end
         end
         ecf_pkg::ECF_DS_SOVER: begin
            // run called routine, stop at return
            if (retire_valid) begin
               if (!st.so_armed && retire_is_call) begin
                  next_st.so_armed = 1'b1;
                  next_st.so_target = retire_ret_pc;
               end else if (!st.so_armed || retire_next_pc == st.so_target || bp_hit) begin
                  next_st.dstate = ecf_pkg::ECF_DS_HALT;
               end
            end
         end
         default: next_st.dstate = ecf_pkg::ECF_DS_HALT;
      endcase

      // debug entry loads pc and sp
      if (dbg_wr && pwdata[ecf_pkg::ECF_DBG_ENTER_BIT] && !st.dbg_mode) begin
         next_st.dbg_mode = 1'b1;
         next_st.pc_load = 1'b1;
         next_st.dstate = ecf_pkg::ECF_DS_HALT;
      end

      // shared pins given to debug port
      if (owns_pins) begin
         next_st.pin_do = {3'h0, jtag_tdo};
         next_st.pin_oe_n = {3'h7, !jtag_tdo_en};
         next_st.gp_di = 4'h0;
         next_st.jtag_di = st.pin_s2;
      end else begin
         next_st.pin_do = gp_do;
         next_st.pin_oe_n = gp_oe_n;
         next_st.gp_di = st.pin_s2;
         next_st.jtag_di = 4'h0;
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.pin_oe_n <= ecf_pkg::ECF_PIN_OE_N_RST;
         st.dstate <= ecf_pkg::ECF_DS_RUN;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = st.prdata;
   assign core_halt = st.dstate == ecf_pkg::ECF_DS_HALT;
   assign core_run = !core_halt;
   assign pc_load = st.pc_load;
   assign pc_load_value = ecf_pkg::ECF_DBG_PC_ENTRY;
   assign sp_load_value = ecf_pkg::ECF_DBG_SP_ENTRY;
   assign dptr_addr = st.pointer_select ? st.second_data_pointer : st.dptr0;
   assign xram_addr = st.xram_addr;
   assign flash_area_sel = st.flash_area_sel;
   assign sfr_page = {st.sfr_page_sel_hi, st.sfr_page_sel_lo};
   assign gp_di = st.gp_di;
   assign jtag_di = st.jtag_di;
   assign pin_do = st.pin_do;
   assign pin_oe_n = st.pin_oe_n;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_enter;
      dbg_wr && pwdata[ecf_pkg::ECF_DBG_ENTER_BIT] && !st.dbg_mode;
   endsequence
   sequence s_call_seen;
      st.dstate == ecf_pkg::ECF_DS_SOVER && !st.so_armed && retire_valid && retire_is_call;
   endsequence

   AST_DBG_ENTRY: assert property (s_enter |=> pc_load && core_halt && pc_load_value == 16'h0000 ##1 !pc_load)
      else $error("debug entry did not load pc and halt");
   AST_DBG_SP: assert property (pc_load |-> sp_load_value == 8'h07 && st.dbg_mode)
      else $error("debug entry stack value wrong");
   AST_BP_HALT: assert property ((st.dstate == ecf_pkg::ECF_DS_RUN && retire_valid && bp_hit && !dbg_wr) |=> core_halt)
      else $error("breakpoint did not halt after instruction");
   AST_SO_CALL: assert property (s_call_seen |=> !core_halt && st.so_target == $past(retire_ret_pc))
      else $error("step over halted inside the call");
   AST_SO_RETURN: assert property ((st.dstate == ecf_pkg::ECF_DS_SOVER && st.so_armed && retire_valid
      && retire_next_pc == st.so_target && !dbg_wr) |=> core_halt)
      else $error("step over missed the return");
   AST_MUL16: assert property ((wr_en && paddr == ecf_pkg::ECF_A_ARITH && pwdata[0] && st.wide_mul_sel)
      |=> {st.breg, st.aux_operand_reg, st.acc} == {$past(st.aux_operand_reg), $past(st.acc)} * $past(st.breg))
      else $error("wide multiply result wrong");
   AST_XRAM_PAGE: assert property ((ri_valid && !wr_en) |=> xram_addr == {$past(st.ext_ram_page), $past(ri_value)})
      else $error("external address high byte not from page");
   AST_DPTR_SEL: assert property ((dptr_inc && st.pointer_select && !wr_en)
      |=> st.second_data_pointer == $past(st.second_data_pointer) + 16'h0001 && $stable(st.dptr0))
      else $error("wrong data pointer incremented");
   AST_PINS_DEBUG: assert property (owns_pins |=> gp_di == 4'h0 && pin_oe_n[3:1] == 3'h7)
      else $error("shared pins still serve general I/O");
   AST_RESET_CLEAR: assert property ($rose(rst_n) |-> !st.pointer_select && !st.wide_mul_sel
      && !st.wide_div_sel && !st.flash_area_sel && sfr_page == 2'h0 && st.ext_ram_page == 8'h00)
      else $error("select bits not cleared by reset");

endmodule // ecf_core_ext

// ==== bench/ecf_emu_model.sv ====
// Behavioural debug emulator that drives the shared debug pins
module ecf_emu_model (
   input wire logic clk,
   input wire logic active,
   output logic jtag_sel,
   output logic jtag_tdo,
   output logic jtag_tdo_en,
   output logic [3:0] pin_ext
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle levels at time zero
   initial begin
      jtag_sel = 1'b0;
      jtag_tdo = 1'b0;
      jtag_tdo_en = 1'b0;
      pin_ext = 4'h5;
   end

   // Session select follows the host; undriven pin levels flip every cycle
   // so that a stale value can never pass for a real one
   always @(posedge clk) begin
      jtag_sel <= active;
      jtag_tdo_en <= active;
      jtag_tdo <= active ? ~jtag_tdo : 1'b0;
      pin_ext <= ~pin_ext;
   end
endmodule // ecf_emu_model

// ==== bench/ecf_core_ext_bench.sv ====
// Self-checking bench for the enhanced core feature block
module ecf_core_ext_bench;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
   logic clk, rstn, psel, penable, pwrite, pready, pslverr, emu_on;
   logic retire_valid, retire_is_call, dptr_inc, ri_valid, core_run, core_halt, pc_load;
   logic [7:0] paddr, ri_value, sp_load_value;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] retire_pc, retire_next_pc, retire_ret_pc, pc_load_value, dptr_addr, xram_addr;
   logic flash_area_sel, jtag_sel, jtag_tdo, jtag_tdo_en;
   logic [1:0] sfr_page;
   logic [3:0] jtag_di, gp_di, pin_do, pin_oe_n, pin_ext, pin_di;
   int mismatches, checks_done;

   ecf_core_ext dut_u (.clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .retire_valid, .retire_pc, .retire_next_pc, .retire_is_call,
      .retire_ret_pc, .dptr_inc, .ri_valid, .ri_value, .core_run, .core_halt, .pc_load,
      .pc_load_value, .sp_load_value, .dptr_addr, .xram_addr, .flash_area_sel, .sfr_page,
      .jtag_sel, .jtag_tdo, .jtag_tdo_en, .jtag_di, .gp_do(4'hA), .gp_oe_n(4'h0), .gp_di,
      .pin_di, .pin_do, .pin_oe_n);
   ecf_emu_model emu_u (.clk, .active(emu_on), .jtag_sel, .jtag_tdo, .jtag_tdo_en, .pin_ext);

   // Pin level: the driving side wins, else the emulator's level
   always_comb for (int i = 0; i < 4; i++) pin_di[i] = pin_oe_n[i] ? pin_ext[i] : pin_do[i];

   // -----------------------------------------------------------------
   // Bus and core helpers
   // -----------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      repeat (2) @(negedge clk);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   task automatic ret(input logic [15:0] pc, nx, input logic call, input logic [15:0] rp);
      @(posedge clk);
      retire_valid <= 1'b1;
      retire_pc <= pc;
      retire_next_pc <= nx;
      retire_is_call <= call;
      retire_ret_pc <= rp;
      @(posedge clk);
      retire_valid <= 1'b0;
      @(negedge clk);
   endtask
   task automatic ld(input logic [7:0] acc, aux, b);
      wr(ecf_pkg::ECF_A_ACC, {24'h0, acc});
      wr(ecf_pkg::ECF_A_AUX, {24'h0, aux});
      wr(ecf_pkg::ECF_A_BREG, {24'h0, b});
   endtask

   // Mid-run low reset clears every select and page bit
   task automatic t_reset();
      wr(ecf_pkg::ECF_A_FLASH, 32'h1);
      wr(ecf_pkg::ECF_A_SFRPG, 32'h3);
      wr(ecf_pkg::ECF_A_EXT_RAM_PAGE, 32'h77);
      wr(ecf_pkg::ECF_A_INSCTL, 32'hD);
      `CHK(flash_area_sel, 1'b1)
      @(posedge clk);
      rstn <= 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK(flash_area_sel, 1'b0)
      `CHK(sfr_page, 2'b00)
      rdchk(ecf_pkg::ECF_A_INSCTL, 32'h0);
      rdchk(ecf_pkg::ECF_A_EXT_RAM_PAGE, 32'h0);
      rdchk(8'h38, 32'h0);
      `CHK(pin_oe_n, 4'h0)
      `CHK(gp_di, 4'hA)
   endtask

   // Wide multiply and divide, then narrow multiply
   task automatic t_arith();
      ld(8'h34, 8'h12, 8'h10);
      wr(ecf_pkg::ECF_A_INSCTL, 32'h8);
      wr(ecf_pkg::ECF_A_ARITH, 32'h1);
      rdchk(ecf_pkg::ECF_A_ACC, 32'h40);
      rdchk(ecf_pkg::ECF_A_AUX, 32'h23);
      rdchk(ecf_pkg::ECF_A_BREG, 32'h01);
      ld(8'h34, 8'h12, 8'h10);
      wr(ecf_pkg::ECF_A_INSCTL, 32'h4);
      wr(ecf_pkg::ECF_A_ARITH, 32'h2);
      rdchk(ecf_pkg::ECF_A_ACC, 32'h23);
      rdchk(ecf_pkg::ECF_A_AUX, 32'h01);
      rdchk(ecf_pkg::ECF_A_BREG, 32'h04);
      wr(ecf_pkg::ECF_A_INSCTL, 32'h0);
      ld(8'h34, 8'h55, 8'h04);
      wr(ecf_pkg::ECF_A_ARITH, 32'h1);
      rdchk(ecf_pkg::ECF_A_ACC, 32'hD0);
      rdchk(ecf_pkg::ECF_A_AUX, 32'h55);
   endtask

   // Two data pointers picked by the select bit
   task automatic t_ptr();
      wr(ecf_pkg::ECF_A_DPTR0, 32'h1111);
      wr(ecf_pkg::ECF_A_SECOND_DATA_POINTER, 32'h2222);
      `CHK(dptr_addr, 16'h1111)
      wr(ecf_pkg::ECF_A_INSCTL, 32'h1);
      `CHK(dptr_addr, 16'h2222)
      @(posedge clk);
      dptr_inc <= 1'b1;
      @(posedge clk);
      dptr_inc <= 1'b0;
      @(negedge clk);
      `CHK(dptr_addr, 16'h2223)
      rdchk(ecf_pkg::ECF_A_DPTR0, 32'h1111);
      wr(ecf_pkg::ECF_A_INSCTL, 32'h0);
      `CHK(dptr_addr, 16'h1111)
   endtask

   // External RAM page, flash area and register pages
   task automatic t_page();
      wr(ecf_pkg::ECF_A_EXT_RAM_PAGE, 32'h05);
      @(posedge clk);
      ri_valid <= 1'b1;
      ri_value <= 8'hAB;
      @(posedge clk);
      ri_valid <= 1'b0;
      @(negedge clk);
      `CHK(xram_addr, 16'h05AB)
      wr(ecf_pkg::ECF_A_FLASH, 32'h1);
      `CHK(flash_area_sel, 1'b1)
      wr(ecf_pkg::ECF_A_FLASH, 32'h0);
      `CHK(flash_area_sel, 1'b0)
      for (int i = 1; i < 4; i++) begin
         wr(ecf_pkg::ECF_A_SFRPG, i);
         `CHK(sfr_page, 2'(i))
      end
   endtask

   // Debug entry, breakpoints and step-over
   task automatic t_debug();
      emu_on <= 1'b1;
      // The load pulse stands one cycle right after the access edge
      apb(1'b1, ecf_pkg::ECF_A_DBGCTL, 32'h1);
      @(negedge clk);
      `CHK(pc_load, 1'b1)
      `CHK(pc_load_value, 16'h0000)
      `CHK(sp_load_value, 8'h07)
      @(negedge clk);
      `CHK(pc_load, 1'b0)
      repeat (4) @(negedge clk);
      `CHK(pin_oe_n, 4'hE)
      `CHK(gp_di, 4'h0)
      wr(ecf_pkg::ECF_A_DBGCTL, 32'h10);
      for (int i = 0; i < 8; i++) wr(ecf_pkg::ECF_A_BPADDR, 32'h0200 + i);
      rdchk(ecf_pkg::ECF_A_DBGSTAT, 32'h73);
      wr(ecf_pkg::ECF_A_DBGCTL, 32'h2);
      ret(16'h0200, 16'h0201, 1'b0, 16'h0);
      `CHK(core_halt, 1'b0)
      ret(16'h0201, 16'h0202, 1'b0, 16'h0);
      `CHK(core_run, 1'b0)
      wr(ecf_pkg::ECF_A_DBGCTL, 32'h8);
      ret(16'h0300, 16'h0400, 1'b1, 16'h0303);
      `CHK(core_halt, 1'b0)
      ret(16'h0400, 16'h0401, 1'b0, 16'h0);
      `CHK(core_halt, 1'b0)
      ret(16'h0401, 16'h0303, 1'b0, 16'h0);
      `CHK(core_halt, 1'b1)
      wr(ecf_pkg::ECF_A_DBGCTL, 32'h20);
      emu_on <= 1'b0;
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Clock at 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Reset, then every scenario in turn
   initial begin
      {rstn, psel, penable, pwrite, paddr, pwdata, emu_on} = '0;
      {retire_valid, retire_pc, retire_next_pc, retire_is_call, retire_ret_pc} = '0;
      {dptr_inc, ri_valid, ri_value} = '0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_arith();
      t_ptr();
      t_page();
      t_debug();
      report_and_stop();
   end
   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end
endmodule // ecf_core_ext_bench
